// [rtl/pms_pkg.sv]
package pms_pkg;
  localparam int CLK_MHZ     = 25;
  localparam int STARTUP_US  = 2500;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int CNT_W       = 17;
  localparam int PD_W        = 8;
  localparam int RET_WORDS   = 5;
  localparam int RET_AW      = 3;
  localparam int RET_DW      = 32;
  // synchroniser bit positions
  localparam int SY_RSTPIN   = 0;
  localparam int SY_BATOK    = 1;
  localparam int SY_FIELD    = 2;
  localparam int SY_FHIGH    = 3;
  localparam int SY_AOLOW    = 4;
  localparam int SY_OSC      = 5;
  localparam int SY_FLASH    = 6;
  localparam int SY_RTC      = 7;
  localparam int SY_WDT      = 8;
  localparam int SY_WAKE     = 9;
  localparam int SY_IRQ      = 10;
  localparam int SYNC_W      = 11;
  // reset and wake pins idle high
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h201;
  localparam logic [CNT_W-1:0]  CNT_RST  = 17'h00000;
  localparam logic [PD_W-1:0]   PD_RST   = 8'h00;
  localparam logic [RET_DW-1:0] RET_RST  = 32'h00000000;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h0,
    ST_DIG  = 3'h1,
    ST_ANA  = 3'h3,
    ST_RST  = 3'h2,
    ST_ACT  = 3'h6,
    ST_SLP  = 3'h7,
    ST_DPD  = 3'h5,
    ST_BOFF = 3'h4
  } pms_state_e;
endpackage : pms_pkg

// [rtl/pms_retention_mem.sv]
module pms_retention_mem (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          we,
  input  wire logic [pms_pkg::RET_AW-1:0]    addr,
  input  wire logic [pms_pkg::RET_DW-1:0]    wdata,
  output logic      [pms_pkg::RET_DW-1:0]    rdata_q
);
  // array has no reset so contents survive deep power-down
  logic [pms_pkg::RET_DW-1:0] mem [pms_pkg::RET_WORDS];

  always_ff @(posedge mclk) begin
    if (we && (int'(addr) < pms_pkg::RET_WORDS)) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= pms_pkg::RET_RST;
    end else if (int'(addr) < pms_pkg::RET_WORDS) begin
      rdata_q <= mem[addr];
    end else begin
      rdata_q <= pms_pkg::RET_RST;
    end
  end
endmodule : pms_retention_mem

// [rtl/pms_power_mode_sequencer.sv]
module pms_power_mode_sequencer #(
  parameter int STARTUP_CYC = pms_pkg::STARTUP_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        reset_pin_n,
  input  wire logic                        battery_above_thr,
  input  wire logic                        field_present,
  input  wire logic                        field_above_battery,
  input  wire logic                        always_on_low,
  input  wire logic                        sysosc_stable,
  input  wire logic                        flash_ready,
  input  wire logic                        rtc_event,
  input  wire logic                        wdt_event,
  input  wire logic                        wake_pin,
  input  wire logic                        start_irq,
  input  wire logic                        auto_select_dis,
  input  wire logic                        bod_enable,
  input  wire logic                        wake_pin_en,
  input  wire logic                        field_wake_en,
  input  wire logic                        sleep_req,
  input  wire logic                        dpd_select,
  input  wire logic                        battery_off_req,
  input  wire logic                        flag_clr,
  input  wire logic [pms_pkg::PD_W-1:0]    pd_config,
  input  wire logic                        ret_we,
  input  wire logic [pms_pkg::RET_AW-1:0]  ret_addr,
  input  wire logic [pms_pkg::RET_DW-1:0]  ret_wdata,
  output logic      [pms_pkg::RET_DW-1:0]  ret_rdata,
  output logic                             battery_power_switch,
  output logic                             field_power_switch,
  output logic                             battery_selected,
  output logic                             digital_regulator_en,
  output logic                             analog_regulator_en,
  output logic                             system_reset_n,
  output logic                             boot_en,
  output logic                             deep_powerdown_flag,
  output logic                             sleep_flag,
  output logic                             dpd_entered,
  output logic                             sleep_entered,
  output logic                             brownout_irq,
  output logic      [pms_pkg::PD_W-1:0]    periph_pwr_en,
  output logic      [2:0]                  pwr_state
);
  localparam int ANA_AT = STARTUP_CYC / 4;
  localparam int REL_AT = STARTUP_CYC / 2;
  localparam int END_AT = STARTUP_CYC - 1;

  logic [pms_pkg::SYNC_W-1:0] sy1_q;
  logic [pms_pkg::SYNC_W-1:0] sy2_q;
  logic                       rpin_prev_q;
  pms_pkg::pms_state_e        state_q;
  pms_pkg::pms_state_e        state_d;
  logic [pms_pkg::CNT_W-1:0]  cnt_q;
  logic                       batsw_q;
  logic                       fldsw_q;
  logic                       selbat_q;
  logic                       selbat_d;
  logic                       dig_q;
  logic                       ana_q;
  logic                       sysrst_n_q;
  logic                       boot_q;
  logic                       dpdf_q;
  logic                       slpf_q;
  logic                       dpd_seen_q;
  logic                       slp_seen_q;
  logic                       bod_q;
  logic [pms_pkg::PD_W-1:0]   pwr_q;

  logic rpin;
  logic rpin_rise;
  logic fld;
  logic osc;
  logic trigger;
  logic wake_slp;
  logic wake_dpd;
  logic powered_d;

  // pin and analog levels pass two flip-flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sy1_q <= pms_pkg::SYNC_RST;
      sy2_q <= pms_pkg::SYNC_RST;
    end else begin
      sy1_q <= {start_irq, wake_pin, wdt_event, rtc_event, flash_ready, sysosc_stable,
                always_on_low, field_above_battery, field_present, battery_above_thr,
                reset_pin_n};
      sy2_q <= sy1_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rpin_prev_q <= 1'b1;
    end else begin
      rpin_prev_q <= sy2_q[pms_pkg::SY_RSTPIN];
    end
  end

  assign rpin      = sy2_q[pms_pkg::SY_RSTPIN];
  assign rpin_rise = rpin & ~rpin_prev_q;
  assign fld       = sy2_q[pms_pkg::SY_FIELD];
  assign osc       = sy2_q[pms_pkg::SY_OSC];
  assign trigger   = rpin_rise | fld;

  assign wake_slp = ~rpin | sy2_q[pms_pkg::SY_RTC] | sy2_q[pms_pkg::SY_WDT]
                  | ~sy2_q[pms_pkg::SY_WAKE] | sy2_q[pms_pkg::SY_IRQ]
                  | (fld & field_wake_en);
  assign wake_dpd = ~rpin | sy2_q[pms_pkg::SY_RTC]
                  | (wake_pin_en & ~sy2_q[pms_pkg::SY_WAKE])
                  | (fld & field_wake_en);

  always_comb begin
    state_d = state_q;
    case (state_q)
      pms_pkg::ST_OFF, pms_pkg::ST_BOFF: begin
        if (trigger) begin
          state_d = pms_pkg::ST_DIG;
        end
      end
      pms_pkg::ST_DIG: begin
        if (int'(cnt_q) >= ANA_AT) begin
          state_d = pms_pkg::ST_ANA;
        end
      end
      pms_pkg::ST_ANA: begin
        if (int'(cnt_q) >= REL_AT && osc) begin
          state_d = pms_pkg::ST_RST;
        end
      end
      pms_pkg::ST_RST: begin
        if (int'(cnt_q) >= END_AT && sy2_q[pms_pkg::SY_FLASH] && rpin) begin
          state_d = pms_pkg::ST_ACT;
        end
      end
      pms_pkg::ST_ACT: begin
        if (battery_off_req && !fld) begin
          state_d = pms_pkg::ST_BOFF;
        end else if (!rpin) begin
          state_d = pms_pkg::ST_RST;
        end else if (sleep_req) begin
          state_d = dpd_select ? pms_pkg::ST_DPD : pms_pkg::ST_SLP;
        end
      end
      pms_pkg::ST_SLP: begin
        if (wake_slp) begin
          state_d = pms_pkg::ST_ACT;
        end
      end
      pms_pkg::ST_DPD: begin
        if (wake_dpd) begin
          state_d = pms_pkg::ST_DIG;
        end
      end
      default: state_d = pms_pkg::ST_OFF;
    endcase
  end

  // runs on every timer oscillator edge, only rstn low stops it and holds it in ST_OFF
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= pms_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= pms_pkg::CNT_RST;
    end else if (state_d == pms_pkg::ST_DIG && state_q != pms_pkg::ST_DIG) begin
      cnt_q <= pms_pkg::CNT_RST;
    end else if (int'(cnt_q) < END_AT) begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end

  // battery preferred unless the override is off, it is low and the field is higher
  assign selbat_d = auto_select_dis
                  | sy2_q[pms_pkg::SY_BATOK]
                  | ~sy2_q[pms_pkg::SY_FHIGH];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      batsw_q  <= 1'b0;
      fldsw_q  <= 1'b0;
      selbat_q <= 1'b1;
    end else begin
      if (state_d == pms_pkg::ST_BOFF) begin
        batsw_q <= 1'b0;
      end else if (trigger) begin
        batsw_q <= 1'b1;
      end
      selbat_q <= selbat_d;
      fldsw_q  <= fld & ~selbat_d;
    end
  end

  assign powered_d = state_d == pms_pkg::ST_DIG || state_d == pms_pkg::ST_ANA
                  || state_d == pms_pkg::ST_RST || state_d == pms_pkg::ST_ACT
                  || state_d == pms_pkg::ST_SLP;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dig_q <= 1'b0;
    end else begin
      dig_q <= powered_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ana_q <= 1'b0;
    end else begin
      ana_q <= powered_d && state_d != pms_pkg::ST_DIG;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sysrst_n_q <= 1'b0;
      boot_q     <= 1'b0;
    end else begin
      sysrst_n_q <= powered_d && state_d != pms_pkg::ST_DIG && state_d != pms_pkg::ST_ANA
                    && dig_q && osc && rpin;
      boot_q     <= (state_d == pms_pkg::ST_ACT) && sy2_q[pms_pkg::SY_FLASH];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dpdf_q <= 1'b0;
      slpf_q <= 1'b0;
    end else begin
      dpdf_q <= state_d == pms_pkg::ST_DPD;
      slpf_q <= state_d == pms_pkg::ST_SLP;
    end
  end

  // set wins over clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dpd_seen_q <= 1'b0;
      slp_seen_q <= 1'b0;
    end else begin
      if (state_d == pms_pkg::ST_DPD && state_q != pms_pkg::ST_DPD) begin
        dpd_seen_q <= 1'b1;
      end else if (flag_clr) begin
        dpd_seen_q <= 1'b0;
      end
      if (state_d == pms_pkg::ST_SLP && state_q != pms_pkg::ST_SLP) begin
        slp_seen_q <= 1'b1;
      end else if (flag_clr) begin
        slp_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bod_q <= 1'b0;
    end else begin
      bod_q <= bod_enable & sy2_q[pms_pkg::SY_AOLOW];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwr_q <= pms_pkg::PD_RST;
    end else if (state_d == pms_pkg::ST_ACT || state_d == pms_pkg::ST_SLP) begin
      pwr_q <= ~pd_config;
    end else begin
      pwr_q <= pms_pkg::PD_RST;
    end
  end

  pms_retention_mem u_ret (
    .mclk    (mclk),
    .rstn    (rstn),
    .we      (ret_we),
    .addr    (ret_addr),
    .wdata   (ret_wdata),
    .rdata_q (ret_rdata)
  );

  assign battery_power_switch = batsw_q;
  assign field_power_switch   = fldsw_q;
  assign battery_selected     = selbat_q;
  assign digital_regulator_en = dig_q;
  assign analog_regulator_en  = ana_q;
  assign system_reset_n       = sysrst_n_q;
  assign boot_en              = boot_q;
  assign deep_powerdown_flag  = dpdf_q;
  assign sleep_flag           = slpf_q;
  assign dpd_entered          = dpd_seen_q;
  assign sleep_entered        = slp_seen_q;
  assign brownout_irq         = bod_q;
  assign periph_pwr_en        = pwr_q;
  assign pwr_state            = state_q;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_off_switch_open: assert property (
    state_q == pms_pkg::ST_OFF && !$past(trigger) |-> !batsw_q)
    else $error("battery switch closed before trigger");
  chk_rise_closes: assert property (
    state_q == pms_pkg::ST_OFF && rpin_rise |=> batsw_q && state_q == pms_pkg::ST_DIG)
    else $error("reset pin rise did not close battery switch");
  chk_battery_priority: assert property (
    sy2_q[pms_pkg::SY_BATOK] && fld |=> selbat_q && !fldsw_q)
    else $error("battery not given priority");
  chk_field_feed: assert property (
    !auto_select_dis && !sy2_q[pms_pkg::SY_BATOK] && sy2_q[pms_pkg::SY_FHIGH] && fld
    |=> !selbat_q && fldsw_q)
    else $error("field supply not selected");
  chk_switchover: assert property (
    !auto_select_dis && fld && sy2_q[pms_pkg::SY_FHIGH] && $fell(sy2_q[pms_pkg::SY_BATOK])
    |=> !selbat_q && fldsw_q)
    else $error("switchover not immediate");
  chk_override: assert property (
    auto_select_dis |=> selbat_q)
    else $error("override did not force battery");
  chk_battery_off: assert property (
    state_q == pms_pkg::ST_ACT && battery_off_req && !fld |=> !batsw_q ##0 !dig_q)
    else $error("battery off not taken");
  chk_brownout: assert property (
    bod_enable && sy2_q[pms_pkg::SY_AOLOW] |=> bod_q)
    else $error("brownout interrupt missing");
  chk_active_code: assert property (
    state_q == pms_pkg::ST_ACT |-> dig_q && ana_q && !dpdf_q && !slpf_q)
    else $error("active state encoding wrong");
  chk_dpd_code: assert property (
    state_q == pms_pkg::ST_DPD |-> dpdf_q && !slpf_q && !dig_q && !ana_q)
    else $error("powerdown state encoding wrong");
  chk_order_regs: assert property (
    $rose(ana_q) |-> dig_q && $past(dig_q, 2))
    else $error("analog regulator before digital");
  chk_reset_release: assert property (
    $rose(sysrst_n_q) |-> dig_q && $past(osc))
    else $error("reset released too early");
  chk_boot_flash: assert property (
    boot_q |-> $past(sy2_q[pms_pkg::SY_FLASH]) && state_q == pms_pkg::ST_ACT)
    else $error("boot without flash ready");
  chk_startup_time: assert property (
    state_q == pms_pkg::ST_ACT && $past(state_q) == pms_pkg::ST_RST |-> int'(cnt_q) == END_AT)
    else $error("start-up shorter than expected");
  chk_dsleep_wake: assert property (
    state_q == pms_pkg::ST_SLP && sy2_q[pms_pkg::SY_WDT] |=> state_q == pms_pkg::ST_ACT)
    else $error("deep-sleep wake missed");
  chk_dpd_wake: assert property (
    state_q == pms_pkg::ST_DPD
    && (sy2_q[pms_pkg::SY_RTC] || (wake_pin_en && !sy2_q[pms_pkg::SY_WAKE]))
    |=> state_q == pms_pkg::ST_DIG)
    else $error("powerdown wake missed");

  cov_boot: cover property (state_q == pms_pkg::ST_RST ##1 state_q == pms_pkg::ST_ACT);
  cov_dpd: cover property (state_q == pms_pkg::ST_DPD ##1 state_q == pms_pkg::ST_DIG);
  cov_sleep: cover property (state_q == pms_pkg::ST_SLP ##1 state_q == pms_pkg::ST_ACT);
  cov_boff: cover property (state_q == pms_pkg::ST_BOFF);
endmodule : pms_power_mode_sequencer

// [test/pms_far_side.sv]
// oscillator and flash seen from the sequencer; slow stretches both wait times
module pms_far_side (
  input  wire logic mclk,
  input  wire logic slow,
  input  wire logic digital_regulator_en,
  input  wire logic analog_regulator_en,
  output logic      sysosc_stable,
  output logic      flash_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int osc_cnt = 0;
  int fl_cnt  = 0;
  // each goes low one clock after its regulator drops
  always @(posedge mclk) begin
    osc_cnt       <= digital_regulator_en ? osc_cnt + 1 : 0;
    fl_cnt        <= analog_regulator_en ? fl_cnt + 1 : 0;
    sysosc_stable <= digital_regulator_en && osc_cnt >= (slow ? 25 : 4);
    flash_ready   <= analog_regulator_en && fl_cnt >= (slow ? 18 : 5);
  end
endmodule : pms_far_side

// [test/pms_power_mode_sequencer_tb.sv]
module pms_power_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 40;
  logic mclk = 1'b0, rstn = 1'b0, reset_pin_n = 1'b1, battery_above_thr = 1'b1;
  logic field_present = 1'b0, field_above_battery = 1'b0, always_on_low = 1'b0;
  logic rtc_event = 1'b0, wdt_event = 1'b0, wake_pin = 1'b1, start_irq = 1'b0;
  logic auto_select_dis = 1'b0, bod_enable = 1'b0, wake_pin_en = 1'b0;
  logic field_wake_en = 1'b0, sleep_req = 1'b0, dpd_select = 1'b0;
  logic battery_off_req = 1'b0, flag_clr = 1'b0, ret_we = 1'b0, slow = 1'b0;
  logic [pms_pkg::PD_W-1:0]   pd_config = 8'h00;
  logic [pms_pkg::RET_AW-1:0] ret_addr = 3'h0;
  logic [pms_pkg::RET_DW-1:0] ret_wdata = 32'h00000000;
  logic [pms_pkg::RET_DW-1:0] ret_rdata;
  logic sysosc_stable, flash_ready, battery_power_switch, field_power_switch;
  logic battery_selected, digital_regulator_en, analog_regulator_en;
  logic system_reset_n, boot_en, deep_powerdown_flag, sleep_flag;
  logic dpd_entered, sleep_entered, brownout_irq;
  logic [pms_pkg::PD_W-1:0] periph_pwr_en;
  logic [2:0]               pwr_state;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n = 0;
  int t0 = 0;
  // {battery ok, field, field higher, override, expected battery source}
  logic [4:0] sel_tab [6] = '{5'h1D, 5'h0C, 5'h1D, 5'h0F, 5'h11, 5'h09};

  pms_power_mode_sequencer #(.STARTUP_CYC(SC)) pms_power_mode_sequencer_i (
    .mclk, .rstn, .reset_pin_n, .battery_above_thr, .field_present,
    .field_above_battery, .always_on_low, .sysosc_stable, .flash_ready,
    .rtc_event, .wdt_event, .wake_pin, .start_irq, .auto_select_dis,
    .bod_enable, .wake_pin_en, .field_wake_en, .sleep_req, .dpd_select,
    .battery_off_req, .flag_clr, .pd_config, .ret_we, .ret_addr, .ret_wdata,
    .ret_rdata, .battery_power_switch, .field_power_switch, .battery_selected,
    .digital_regulator_en, .analog_regulator_en, .system_reset_n, .boot_en,
    .deep_powerdown_flag, .sleep_flag, .dpd_entered, .sleep_entered,
    .brownout_irq, .periph_pwr_en, .pwr_state
  );

  pms_far_side pms_far_side_i (
    .mclk, .slow, .digital_regulator_en, .analog_regulator_en,
    .sysosc_stable, .flash_ready
  );

  always #20 mclk = ~mclk;

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 12000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (pwr_state !== s && n < lim) begin
      tick(1);
      n++;
    end
    chk(32'(pwr_state), 32'(s), "state");
  endtask : wait_st

  task automatic enter_low(input logic dpd);
    dpd_select = dpd;
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
  endtask : enter_low

  initial begin
    tick(20);
    rstn = 1'b1;
    tick(4);
    chk(32'({battery_power_switch, battery_selected}), 32'h1, "idle switch");
    reset_pin_n = 1'b0;
    tick(5);
    chk(32'(battery_power_switch), 32'h0, "switch before edge");
    reset_pin_n = 1'b1;
    t0 = cyc;
    wait_st(pms_pkg::ST_DIG, 6);
    chk(32'({battery_power_switch, digital_regulator_en, analog_regulator_en}),
        32'h6, "first step");
    wait_st(pms_pkg::ST_ANA, SC);
    chk(32'({analog_regulator_en, system_reset_n}), 32'h2, "second step");
    wait_st(pms_pkg::ST_RST, SC);
    chk(32'({system_reset_n, boot_en}), 32'h2, "reset released");
    wait_st(pms_pkg::ST_ACT, SC);
    chk(32'(cyc - t0 inside {[SC:SC + 6]}), 32'h1, "start-up length");
    chk(32'({boot_en, deep_powerdown_flag, sleep_flag}), 32'h4, "active");
    for (int i = 0; i < 6; i++) begin
      {battery_above_thr, field_present, field_above_battery, auto_select_dis} = sel_tab[i][4:1];
      tick(4);
      chk(32'(battery_selected), 32'(sel_tab[i][0]), "source");
      chk(32'(field_power_switch), 32'(sel_tab[i][3] & ~sel_tab[i][0]), "fld switch");
    end
    {battery_above_thr, field_present, field_above_battery, auto_select_dis} = 4'h8;
    bod_enable = 1'b1;
    always_on_low = 1'b1;
    tick(4);
    chk(32'(brownout_irq), 32'h1, "brownout");
    bod_enable = 1'b0;
    tick(2);
    chk(32'(brownout_irq), 32'h0, "brownout off");
    always_on_low = 1'b0;
    pd_config = 8'hA5;
    tick(2);
    chk(32'(periph_pwr_en), 32'h5A, "peripheral gates");
    ret_we = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ret_addr = 3'(i);
      ret_wdata = 32'hC0DE0000 | 32'(i);
      tick(1);
    end
    ret_we = 1'b0;
    reset_pin_n = 1'b0;
    wait_st(pms_pkg::ST_RST, 5);
    chk(32'({system_reset_n, boot_en}), 32'h0, "pin reset");
    reset_pin_n = 1'b1;
    wait_st(pms_pkg::ST_ACT, 200);
    for (int i = 0; i < 5; i++) begin
      enter_low(1'b0);
      wait_st(pms_pkg::ST_SLP, 4);
      chk(32'({sleep_flag, sleep_entered, digital_regulator_en, analog_regulator_en,
               deep_powerdown_flag}), 32'h1E, "sleep");
      case (i)
        0: rtc_event = 1'b1;
        1: wdt_event = 1'b1;
        2: wake_pin = 1'b0;
        3: start_irq = 1'b1;
        default: {field_present, field_wake_en} = 2'h3;
      endcase
      wait_st(pms_pkg::ST_ACT, 6);
      {rtc_event, wdt_event, start_irq, field_present, field_wake_en} = 5'h00;
      wake_pin = 1'b1;
      tick(4);
    end
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    tick(1);
    chk(32'(sleep_entered), 32'h0, "flag clear");
    slow = 1'b1;
    enter_low(1'b1);
    wait_st(pms_pkg::ST_DPD, 4);
    chk(32'({deep_powerdown_flag, sleep_flag, digital_regulator_en, analog_regulator_en,
             system_reset_n, dpd_entered}), 32'h21, "powerdown");
    {wake_pin, wdt_event, start_irq} = 3'h3;
    tick(200);
    chk(32'(pwr_state), 32'(pms_pkg::ST_DPD), "no wake");
    {wake_pin, wdt_event, start_irq, wake_pin_en} = 4'h9;
    tick(4);
    wake_pin = 1'b0;
    wait_st(pms_pkg::ST_DIG, 6);
    chk(32'(analog_regulator_en), 32'h0, "restart order");
    wait_st(pms_pkg::ST_ANA, SC);
    wait_st(pms_pkg::ST_ACT, 2 * SC);
    tick(2500);
    wake_pin = 1'b1;
    {slow, wake_pin_en, dpd_select} = 3'h0;
    for (int i = 0; i < 6; i++) begin
      ret_addr = 3'(i);
      tick(2);
      chk(ret_rdata, i < 5 ? 32'hC0DE0000 | 32'(i) : 32'h0, "retention");
    end
    // field must be seen through its synchroniser before the off request arrives
    field_present = 1'b1;
    tick(4);
    battery_off_req = 1'b1;
    tick(6);
    chk(32'(pwr_state), 32'(pms_pkg::ST_ACT), "off refused");
    field_present = 1'b0;
    wait_st(pms_pkg::ST_BOFF, 6);
    chk(32'({battery_power_switch, digital_regulator_en, analog_regulator_en}),
        32'h0, "battery off");
    {battery_off_req, battery_above_thr, field_above_battery} = 3'h1;
    tick(4);
    field_present = 1'b1;
    wait_st(pms_pkg::ST_DIG, 6);
    chk(32'({field_power_switch, battery_selected}), 32'h2, "field start");
    wait_st(pms_pkg::ST_ACT, 2 * SC);
    close_out();
  end
endmodule : pms_power_mode_sequencer_tb
